//--- hw/bit_rate_params.svh
`ifndef BIT_RATE_PARAMS_SVH
`define BIT_RATE_PARAMS_SVH
// register offsets (plain port address)
`define OFS_RELOAD 3'h0
`define OFS_BUFFER 3'h1
`define OFS_CTRL_ONE 3'h2
`define OFS_CTRL_TWO 3'h3
`define OFS_CTRL_THREE 3'h4
`define OFS_MASK 3'h5
`define OFS_STATUS 3'h6
// field positions
`define CTRL_ONE_EN_BIT 5
`define CTRL_TWO_HALT_BIT 2
`define STATUS_STOP_BIT 4
`define STATUS_COLL_BIT 6
`define STATUS_EVENT_BIT 7
// mode codes
`define MODE_I2C_MASTER 4'h8
`define MODE_SPI_MASTER_BRG 4'h0
`define MODE_SPI_MASTER_ADD 4'hA
// reset values
`define RESET_BYTE 8'h00
`define RESET_RELOAD 8'h09
// tick divider, not used; the counter ticks once every second system clock
`define TICK_DIV 1'b1
`endif

//--- hw/bit_rate_pkg.sv
package bit_rate_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SDA_LOW = 3'b001,
      ST_SCL_REL = 3'b011,
      ST_WAIT_SDA = 3'b010,
      ST_SDA_REL = 3'b110,
      ST_FINISH = 3'b111
   } stop_state_e;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } line_drive_s;
endpackage

//--- hw/i2c_master_brg_stop_collision.sv
// Operation
// - stop: drive sda low, then release scl
// - scl seen high: reload counter, expire, sample
// - sda low after counter expiry: collision
// - scl low before sda release: collision
// - counter clocks i2c and spi master
// - buffer write starts the counter
// - counter stops at end, scl holds
// - reload strobe twice per serial period
// - serial clock is osc over 4(reload+1)
// - collision sets flag, port goes idle
// - collision aborts stop, releases, clears request
// - stop: sda release, stop seen, event
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bit_rate_params.svh"
module i2c_master_brg_stop_collision (
   input wire logic clk,
   input wire logic rst,
   input wire bit_rate_pkg::reg_req_s req,
   output logic [7:0] rdata,
   input wire logic scl_i,
   input wire logic sda_i,
   output bit_rate_pkg::line_drive_s drive,
   output logic serial_clk
);
   import bit_rate_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] bit_rate_reload_q;
   logic [7:0] serial_shift_buffer_q;
   logic [7:0] serial_control_one_q;
   logic [7:0] serial_control_two_q;
   logic [7:0] serial_control_three_q;
   logic [7:0] address_match_mask_q;
   logic stop_seen_q;
   logic collision_flag_q;
   logic serial_event_flag_q;
   logic [7:0] rdata_q;
   logic [7:0] count_q;
   logic tick_q;
   logic running_q;
   logic half_q;
   logic serial_clk_q;
   stop_state_e state_q;
   logic scl_drive_low_q;
   logic sda_drive_low_q;
   logic [2:0] scl_sync_q;
   logic [2:0] sda_sync_q;
   logic scl_in_q;
   logic sda_in_q;

   // decode helper
   function automatic logic hit(input reg_req_s r, input logic [2:0] ofs);
      hit = r.wr && (r.addr == ofs);
   endfunction

   logic wr_buf;
   logic halt_req;
   logic mode_i2c;
   logic mode_spi;
   logic expire;
   logic reload;
   logic stop_done;
   logic coll_set;
   logic stop_seen_set;
   logic halt_clear;

   assign wr_buf = hit(req, `OFS_BUFFER);
   assign halt_req = serial_control_two_q[`CTRL_TWO_HALT_BIT];
   assign mode_i2c = serial_control_one_q[`CTRL_ONE_EN_BIT]
                     && (serial_control_one_q[3:0] == `MODE_I2C_MASTER);
   assign mode_spi = serial_control_one_q[`CTRL_ONE_EN_BIT]
                     && (serial_control_one_q[3:0] == `MODE_SPI_MASTER_ADD);

   // ----------------------------------------
   // pin input filters
   // ----------------------------------------
   // three stages; level moves when stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
      end else begin
         scl_sync_q <= {scl_sync_q[1:0], scl_i};
         sda_sync_q <= {sda_sync_q[1:0], sda_i};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_in_q <= 1'b1;
         sda_in_q <= 1'b1;
      end else begin
         if (scl_sync_q[1] == scl_sync_q[2]) scl_in_q <= scl_sync_q[2];
         if (sda_sync_q[1] == sda_sync_q[2]) sda_in_q <= sda_sync_q[2];
      end
   end

   // ----------------------------------------
   // bit rate counter
   // ----------------------------------------
   // tick every second system clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) tick_q <= 1'b0;
      else tick_q <= running_q ? ~tick_q : 1'b0;
   end

   assign expire = running_q && tick_q && (count_q == 8'h00);
   // reload strobe: buffer write, expiry, or stop sequencer load
   assign reload = wr_buf || expire
                   || ((state_q == ST_SCL_REL) && scl_in_q);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= `RESET_BYTE;
      end else if (reload) begin
         count_q <= bit_rate_reload_q;
      end else if (running_q && tick_q) begin
         count_q <= count_q - 8'h01;
      end
   end

   // run control: write starts, end of operation stops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         running_q <= 1'b0;
      end else if (wr_buf && (mode_i2c || mode_spi)) begin
         running_q <= 1'b1;
      end else if ((state_q == ST_SCL_REL) && scl_in_q) begin
         running_q <= 1'b1;
      end else if (stop_done || coll_set) begin
         running_q <= 1'b0;
      end
   end

   // serial clock: toggles on each expiry while the stop sequencer is idle, two per period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         half_q <= 1'b0;
         serial_clk_q <= 1'b0;
      end else if (expire && (mode_spi || mode_i2c) && (state_q == ST_IDLE)) begin
         half_q <= ~half_q;
         serial_clk_q <= ~serial_clk_q;
      end
   end
   assign serial_clk = serial_clk_q;

   // ----------------------------------------
   // stop sequencer
   // ----------------------------------------
   assign stop_done = (state_q == ST_FINISH) && expire;
   assign coll_set = ((state_q == ST_WAIT_SDA) && !scl_in_q)
                     || ((state_q == ST_SDA_REL) && expire && !sda_in_q);
   assign stop_seen_set = (state_q == ST_SDA_REL) && expire && sda_in_q && scl_in_q;
   assign halt_clear = stop_done || coll_set;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (halt_req && mode_i2c) state_q <= ST_SDA_LOW;
            end
            ST_SDA_LOW: begin
               if (!sda_in_q) state_q <= ST_SCL_REL;
            end
            ST_SCL_REL: begin
               if (scl_in_q) state_q <= ST_WAIT_SDA;
            end
            ST_WAIT_SDA: begin
               if (coll_set) state_q <= ST_IDLE;
               else if (expire) state_q <= ST_SDA_REL;
            end
            ST_SDA_REL: begin
               if (coll_set) state_q <= ST_IDLE;
               else if (expire) state_q <= ST_FINISH;
            end
            ST_FINISH: begin
               if (expire) state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // pin drive: sda low first, scl low until released
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_drive_low_q <= 1'b0;
         scl_drive_low_q <= 1'b0;
      end else if (coll_set) begin
         sda_drive_low_q <= 1'b0;
         scl_drive_low_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (halt_req && mode_i2c) begin
                  sda_drive_low_q <= 1'b1;
                  scl_drive_low_q <= 1'b1;
               end
            end
            ST_SDA_LOW: begin
               if (!sda_in_q) scl_drive_low_q <= 1'b0;
            end
            ST_WAIT_SDA: begin
               if (expire) sda_drive_low_q <= 1'b0;
            end
            default: begin
               sda_drive_low_q <= sda_drive_low_q;
               scl_drive_low_q <= scl_drive_low_q;
            end
         endcase
      end
   end

   assign drive.scl_o = 1'b0;
   assign drive.sda_o = 1'b0;
   assign drive.scl_oe = scl_drive_low_q;
   assign drive.sda_oe = sda_drive_low_q;

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   // plain storage registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_rate_reload_q <= `RESET_RELOAD;
         serial_shift_buffer_q <= `RESET_BYTE;
         serial_control_one_q <= `RESET_BYTE;
         serial_control_three_q <= `RESET_BYTE;
         address_match_mask_q <= `RESET_BYTE;
      end else begin
         if (hit(req, `OFS_RELOAD)) bit_rate_reload_q <= req.wdata;
         if (wr_buf) serial_shift_buffer_q <= req.wdata;
         if (hit(req, `OFS_CTRL_ONE)) serial_control_one_q <= req.wdata;
         if (hit(req, `OFS_CTRL_THREE)) serial_control_three_q <= req.wdata;
         if (hit(req, `OFS_MASK)) address_match_mask_q <= req.wdata;
      end
   end

   // control two: hardware clears the halt request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serial_control_two_q <= `RESET_BYTE;
      end else if (hit(req, `OFS_CTRL_TWO)) begin
         serial_control_two_q <= req.wdata;
      end else if (halt_clear) begin
         serial_control_two_q[`CTRL_TWO_HALT_BIT] <= 1'b0;
      end
   end

   // sticky status; write one clears, hardware set wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stop_seen_q <= 1'b0;
         collision_flag_q <= 1'b0;
         serial_event_flag_q <= 1'b0;
      end else begin
         stop_seen_q <= stop_seen_set || (stop_seen_q && !(hit(req, `OFS_STATUS)
                        && req.wdata[`STATUS_STOP_BIT]));
         collision_flag_q <= coll_set || (collision_flag_q && !(hit(req, `OFS_STATUS)
                             && req.wdata[`STATUS_COLL_BIT]));
         serial_event_flag_q <= stop_done || (serial_event_flag_q
                                && !(hit(req, `OFS_STATUS)
                                && req.wdata[`STATUS_EVENT_BIT]));
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= `RESET_BYTE;
      end else if (req.rd) begin
         case (req.addr)
            `OFS_RELOAD: rdata_q <= bit_rate_reload_q;
            `OFS_BUFFER: rdata_q <= serial_shift_buffer_q;
            `OFS_CTRL_ONE: rdata_q <= serial_control_one_q;
            `OFS_CTRL_TWO: rdata_q <= serial_control_two_q;
            `OFS_CTRL_THREE: rdata_q <= serial_control_three_q;
            `OFS_MASK: rdata_q <= address_match_mask_q;
            `OFS_STATUS: rdata_q <= {serial_event_flag_q, collision_flag_q, 1'b0,
                                     stop_seen_q, 4'h0};
            default: rdata_q <= `RESET_BYTE;
         endcase
      end else begin
         rdata_q <= `RESET_BYTE;
      end
   end
   assign rdata = rdata_q;
endmodule
`default_nettype wire

//--- verif/i2c_stop_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "bit_rate_params.svh"
module i2c_stop_properties (
   input wire logic clk,
   input wire logic rst,
   input wire bit_rate_pkg::reg_req_s req,
   input wire logic [7:0] rdata,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire bit_rate_pkg::line_drive_s drive,
   input wire logic serial_clk
);
   import bit_rate_pkg::*;
   logic [7:0] rel_q;
   logic [9:0] cnt_q;
   logic sc_q;
   logic ok_q;
   logic i2c_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------
   // checks
   // ----------
   // reload copy, mode copy and cycles since the serial clock last moved
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rel_q <= `RESET_RELOAD;
         cnt_q <= 10'h001;
         sc_q <= 1'b0;
         ok_q <= 1'b0;
         i2c_q <= 1'b0;
      end else begin
         sc_q <= serial_clk;
         cnt_q <= (serial_clk != sc_q) ? 10'h001 : cnt_q + 10'h001;
         ok_q <= (ok_q || serial_clk != sc_q) && !req.wr && !drive.sda_oe;
         if (req.wr && req.addr == `OFS_RELOAD) begin
            rel_q <= req.wdata;
         end
         if (req.wr && req.addr == `OFS_CTRL_ONE) begin
            i2c_q <= req.wdata[`CTRL_ONE_EN_BIT] && req.wdata[3:0] == `MODE_I2C_MASTER;
         end
      end
   end
   AST_OPEN_DRAIN: assert property (!drive.scl_o && !drive.sda_o)
      else $error("line driven high");
   AST_STOP_START: assert property (req.wr && req.addr == `OFS_CTRL_TWO && i2c_q
      && req.wdata[`CTRL_TWO_HALT_BIT] && !drive.sda_oe && !drive.scl_oe
      |-> ##2 drive.sda_oe && drive.scl_oe) else $error("stop did not start");
   AST_SCL_AFTER_SDA: assert property ($fell(drive.scl_oe) |-> drive.sda_oe && !$past(sda_i, 2))
      else $error("scl released before sda low");
   AST_SDA_HOLD: assert property ($fell(drive.scl_oe) |-> drive.sda_oe [*8])
      else $error("sda released too early");
   AST_HALF_PERIOD: assert property (ok_q && serial_clk != sc_q
      |-> cnt_q == ({2'b00, rel_q} + 10'h001) * 10'h002) else $error("half period wrong");
   AST_SCL_COLL: assert property ((drive.sda_oe && !drive.scl_oe && scl_i) [*6]
      ##1 !scl_i [*6] |-> ##[0:3] !drive.sda_oe) else $error("scl collision missed");
   AST_NO_SELF_START: assert property ($rose(drive.sda_oe) |-> $past(req.wr, 2) && drive.scl_oe)
      else $error("stop started unasked");
   AST_RELEASE_ORDER: assert property ($fell(drive.sda_oe) |-> !drive.scl_oe)
      else $error("sda released with scl held");
   cover property ($rose(drive.sda_oe));
   cover property ($fell(drive.sda_oe) && scl_i);
   cover property (drive.sda_oe && !drive.scl_oe && !scl_i);
endmodule
bind i2c_master_brg_stop_collision i2c_stop_properties i2c_stop_properties_i (.clk(clk),
   .rst(rst), .req(req), .rdata(rdata), .scl_i(scl_i), .sda_i(sda_i), .drive(drive),
   .serial_clk(serial_clk));
`default_nettype wire

//--- verif/bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
module bus_peer (
   input wire logic clk,
   input wire logic rst,
   input wire bit_rate_pkg::line_drive_s drive,
   input wire logic [3:0] stretch,
   input wire logic hold_sda,
   input wire logic grab_scl,
   output logic scl_i,
   output logic sda_i
);
   import bit_rate_pkg::*;
   logic [3:0] st_q;
   logic [2:0] hi_q;
   logic grab_q;
   // ----------
   // other party on a wired-and bus with pull-ups
   // ----------
   assign scl_i = !(drive.scl_oe || st_q != 4'h0 || grab_q);
   assign sda_i = !(drive.sda_oe || hold_sda);
   // stretch scl after release, grab it after a high spell
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= 4'h0;
         hi_q <= 3'h0;
         grab_q <= 1'b0;
      end else begin
         st_q <= drive.scl_oe ? stretch : st_q - {3'h0, st_q != 4'h0};
         hi_q <= (!scl_i || drive.scl_oe) ? 3'h0 : hi_q + {2'h0, hi_q != 3'h7};
         grab_q <= grab_scl && (grab_q || (hi_q == 3'h6 && drive.sda_oe));
      end
   end
endmodule
`default_nettype wire

//--- verif/tb_i2c_master_brg_stop_collision.sv
`timescale 1ns/1ps
`default_nettype none
`include "bit_rate_params.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_i2c_master_brg_stop_collision;
   import bit_rate_pkg::*;
   logic clk, rst, scl_i, sda_i, serial_clk, hold_sda, grab_scl;
   logic [3:0] stretch;
   logic [7:0] rdata, d;
   reg_req_s req;
   line_drive_s drive;
   int error_cnt, n_compared, t;
   i2c_master_brg_stop_collision i2c_master_brg_stop_collision_i (.clk(clk), .rst(rst),
      .req(req), .rdata(rdata), .scl_i(scl_i), .sda_i(sda_i), .drive(drive),
      .serial_clk(serial_clk));
   bus_peer bus_peer_i (.clk(clk), .rst(rst), .drive(drive), .stretch(stretch),
      .hold_sda(hold_sda), .grab_scl(grab_scl), .scl_i(scl_i), .sda_i(sda_i));
   // ----------
   // clock, bus tasks and scenarios
   // ----------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      req.addr <= a;
      req.wdata <= v;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   // read data stands in the cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // one full half period of the serial clock, after one edge to align
   task automatic half(input logic [7:0] mode, input logic [7:0] r);
      logic s;
      wr(`OFS_RELOAD, r);
      wr(`OFS_CTRL_ONE, mode);
      wr(`OFS_BUFFER, 8'h5A);
      for (int k = 0; k < 2; k++) begin
         s = serial_clk;
         t = 0;
         while (serial_clk === s && t < 600) begin
            @(posedge clk);
            #1;
            t++;
         end
      end
      `CHK("half period", 2 * (r + 1), t)
   endtask
   // one stop request with the far side behaving as told
   task automatic stop_case(input logic hs, input logic gs, input logic [3:0] sr,
         input logic [7:0] e);
      @(posedge clk);
      hold_sda <= hs;
      grab_scl <= gs;
      stretch <= sr;
      wr(`OFS_CTRL_TWO, 8'h04);
      t = 0;
      d = 8'h00;
      while ((d & 8'hC0) == 8'h00 && t < 100) begin
         rd(`OFS_STATUS);
         t++;
      end
      `CHK("status", e, d & 8'hD0)
      rd(`OFS_CTRL_TWO);
      `CHK("halt bit", 8'h00, d)
      `CHK("line enables", 2'b00, {drive.scl_oe, drive.sda_oe})
      @(posedge clk);
      hold_sda <= 1'b0;
      grab_scl <= 1'b0;
      repeat (40) @(posedge clk);
      `CHK("idle enables", 2'b00, {drive.scl_oe, drive.sda_oe})
      wr(`OFS_STATUS, 8'hD0);
      rd(`OFS_STATUS);
      `CHK("status clear", 8'h00, d & 8'hD0)
   endtask
   task automatic results;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      req = '0;
      rst = 1'b1;
      {hold_sda, grab_scl, stretch} = 6'h00;
      {error_cnt, n_compared} = 64'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rd(3'(i));
         `CHK("reset value", (i == 0) ? `RESET_RELOAD : `RESET_BYTE, d)
      end
      wr(`OFS_MASK, 8'hA5);
      wr(3'h7, 8'hFF);
      rd(`OFS_MASK);
      `CHK("mask", 8'hA5, d)
      rd(3'h7);
      `CHK("unmapped", 8'h00, d)
      half(8'h28, 8'h03);
      half(8'h2A, 8'h05);
      wr(`OFS_RELOAD, 8'h06);
      wr(`OFS_CTRL_ONE, 8'h28);
      stop_case(1'b0, 1'b0, 4'd5, 8'h90);
      stop_case(1'b1, 1'b0, 4'd0, 8'h40);
      stop_case(1'b0, 1'b1, 4'd0, 8'h40);
      half(8'h28, 8'h06);
      results();
   end
   // cut a hang short
   initial begin
      #500_000;
      error_cnt++;
      $display("unexpected watchdog exp done got hung");
      results();
   end
endmodule
`default_nettype wire
